// File: core/lock_current_consts.svh
// Constants for the lock-current fault handler: offsets, fields, resets, timing
// Behaviour
// - Comparator lock threshold comes from bits 26..23, 0.125 A up to 8.0 A.
// - ADC lock threshold comes from bits 22..19 with the same sixteen steps.
// - Response codes 0 and 1: latch fault, assert fault pin, tristate bridge.
// - Response code 2: latch fault, assert fault pin, brake on high side.
// - Response code 3: latch fault, assert fault pin, brake on low side.
// - Codes 4 to 7: clear fault after retry wait, counting each retry.
// - Retries beyond cap latch; tristate for 4/5, high brake 6, low brake 7.
// - Code 8: report with fault pin asserted, bridge keeps running.
// - Codes 9 to F: lock detection disabled, no fault raised.
// - Filter time from bits 14..11, codes 2..F give 0.2 ms to 1000 ms.
`ifndef LOCK_CURRENT_CONSTS_SVH
`define LOCK_CURRENT_CONSTS_SVH

// Register indices; byte address is four times the index
`define FS1_INDEX      10'h090
`define CTRL_INDEX     10'h0a0
`define STAT_INDEX     10'h0a1
`define MASK_INDEX     10'h0a2
`define INFO_INDEX     10'h0a3

// Field positions in fault_settings_one (all four bits wide)
`define CMP_THR_LSB    23
`define ADC_THR_LSB    19
`define RESP_LSB       15
`define FILT_LSB       11

// Control register layout
`define CTRL_CLEAR_BIT 0
`define CAP_LSB        4
`define WAIT_LSB       16

// Status and mask bits
`define ST_DETECT      0
`define ST_LATCH       1
`define ST_RETRY       2
`define ST_EXHAUST     3

// Reset values
`define FS1_RESET      32'h0000_0000
`define CTRL_RESET     32'h000a_0030
`define MASK_RESET     4'h0

// Timing: filter and retry times count ticks of 0.1 ms
`define CLK_FREQ_HZ    50000000
`define TICK_TIME_US   100
`define TICK_CYCLES    (`TICK_TIME_US * (`CLK_FREQ_HZ / 1000000))

// Filter times in ticks for codes 2..F
`define FILT_T2        14'h0002
`define FILT_T3        14'h0005
`define FILT_T4        14'h000a
`define FILT_T5        14'h0019
`define FILT_T6        14'h0032
`define FILT_T7        14'h004b
`define FILT_T8        14'h0064
`define FILT_T9        14'h00fa
`define FILT_TA        14'h01f4
`define FILT_TB        14'h02ee
`define FILT_TC        14'h03e8
`define FILT_TD        14'h07d0
`define FILT_TE        14'h1388
`define FILT_TF        14'h2710

// Current thresholds in mA for codes 0..F
`define THR_0          16'h007d
`define THR_1          16'h00fa
`define THR_2          16'h01f4
`define THR_3          16'h03e8
`define THR_4          16'h05dc
`define THR_5          16'h07d0
`define THR_6          16'h09c4
`define THR_7          16'h0bb8
`define THR_8          16'h0dac
`define THR_9          16'h0fa0
`define THR_A          16'h1194
`define THR_B          16'h1388
`define THR_C          16'h157c
`define THR_D          16'h1770
`define THR_E          16'h1b58
`define THR_F          16'h1f40

`endif

// File: core/lock_pkg.sv
// Types shared by the lock-current fault handler
package lock_pkg;
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_RETRY   = 4'b0010,
        ST_LATCHED = 4'b0100,
        ST_REPORT  = 4'b1000
    } lock_state_t;

    typedef struct packed {
        logic hiz;
        logic hs_on;
        logic ls_on;
    } bridge_cmd_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [11:0] address;
        logic [31:0] writedata;
    } avs_req_t;
endpackage : lock_pkg

// File: core/lock_lookup_rom.sv
// Registered lookup of threshold currents and filter times
`timescale 1ns/1ps
`include "lock_current_consts.svh"
module lock_lookup_rom (
    input  wire logic        ref_clk,     // Clock
    input  wire logic [3:0]  cmp_code,    // Comparator threshold code
    input  wire logic [3:0]  adc_code,    // ADC threshold code
    input  wire logic [3:0]  filt_code,   // Filter time code
    output logic      [15:0] cmp_thr_ma,  // Comparator threshold, mA
    output logic      [15:0] adc_thr_ma,  // ADC threshold, mA
    output logic      [13:0] filt_ticks   // Filter time, ticks
);
    // Shared decode for both threshold fields
    function automatic logic [15:0] thr_ma(input logic [3:0] c);
        case (c)
            4'h0: thr_ma = `THR_0;
            4'h1: thr_ma = `THR_1;
            4'h2: thr_ma = `THR_2;
            4'h3: thr_ma = `THR_3;
            4'h4: thr_ma = `THR_4;
            4'h5: thr_ma = `THR_5;
            4'h6: thr_ma = `THR_6;
            4'h7: thr_ma = `THR_7;
            4'h8: thr_ma = `THR_8;
            4'h9: thr_ma = `THR_9;
            4'ha: thr_ma = `THR_A;
            4'hb: thr_ma = `THR_B;
            4'hc: thr_ma = `THR_C;
            4'hd: thr_ma = `THR_D;
            4'he: thr_ma = `THR_E;
            default: thr_ma = `THR_F;
        endcase
    endfunction : thr_ma

    // Codes 0 and 1 have no time; they fall back to the shortest
    function automatic logic [13:0] filt_of(input logic [3:0] c);
        case (c)
            4'h3: filt_of = `FILT_T3;
            4'h4: filt_of = `FILT_T4;
            4'h5: filt_of = `FILT_T5;
            4'h6: filt_of = `FILT_T6;
            4'h7: filt_of = `FILT_T7;
            4'h8: filt_of = `FILT_T8;
            4'h9: filt_of = `FILT_T9;
            4'ha: filt_of = `FILT_TA;
            4'hb: filt_of = `FILT_TB;
            4'hc: filt_of = `FILT_TC;
            4'hd: filt_of = `FILT_TD;
            4'he: filt_of = `FILT_TE;
            4'hf: filt_of = `FILT_TF;
            default: filt_of = `FILT_T2;
        endcase
    endfunction : filt_of

    // Registered read data
    always_ff @(posedge ref_clk) begin
        cmp_thr_ma <= thr_ma(cmp_code);
        adc_thr_ma <= thr_ma(adc_code);
        filt_ticks <= filt_of(filt_code);
    end
endmodule : lock_lookup_rom

// File: core/lock_current_fault_handler.sv
// Lock-current fault detection, response and register file
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`include "lock_current_consts.svh"
module lock_current_fault_handler #(
    parameter int TICK_CYCLES = `TICK_CYCLES  // Clock cycles per 0.1 ms tick
) (
    input  wire logic              ref_clk,          // 50 MHz clock
    input  wire logic              reset_n,          // Sync reset, active low
    input  wire lock_pkg::avs_req_t avs_req,         // Avalon request group
    output logic            [31:0] avs_readdata,     // Avalon read data
    output logic                   avs_waitrequest,  // Avalon wait
    input  wire logic              cmp_trip,         // Comparator trip pin
    input  wire logic       [15:0] adc_current_ma,   // Phase current sample, mA
    input  wire logic              adc_valid,        // Sample strobe
    output logic            [15:0] cmp_threshold_ma, // Comparator threshold
    output logic                   fault_indicator_pin_n, // Fault, active low
    output lock_pkg::bridge_cmd_t  bridge,           // Gate driver command
    output logic                   irq               // Interrupt, level
);
    import lock_pkg::*;

    logic [31:0] fs1_r;
    logic [31:0] ctrl_r;
    logic [3:0]  status_r;
    logic [3:0]  status_nxt;
    logic [3:0]  mask_r;
    logic        clear_r;
    logic        wait_r;
    logic [31:0] rdata_r;
    logic [31:0] rd_mux;
    logic        wr_en;
    logic        cmp_meta_r;
    logic        cmp_sync_r;
    logic        adc_over_r;
    logic        over;
    logic [15:0] adc_thr_ma;
    logic [13:0] filt_ticks;
    logic [15:0] pre_r;
    logic [13:0] deg_r;
    logic        detect_en;
    logic        lock_event;
    logic [15:0] rpre_r;
    logic [15:0] rticks_r;
    logic        retry_done;
    logic [3:0]  retry_cnt_r;
    lock_state_t state_r;
    lock_state_t state_nxt;
    bridge_cmd_t action_r;
    bridge_cmd_t action_nxt;
    bridge_cmd_t bridge_r;
    logic        fault_n_r;
    logic        irq_r;
    logic [3:0]  resp;
    logic [3:0]  cap;
    logic [15:0] retry_wait;
    logic        exhaust;

    // Word hit for a register index
    function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction : hit

    // Bridge action for a response code
    function automatic bridge_cmd_t action_of(input logic [3:0] c);
        bridge_cmd_t b;
        b = '{hiz: 1'b0, hs_on: 1'b0, ls_on: 1'b0};
        case (c)
            4'h0, 4'h1, 4'h4, 4'h5: b.hiz = 1'b1;
            4'h2, 4'h6: b.hs_on = 1'b1;
            4'h3, 4'h7: b.ls_on = 1'b1;
            default: b.hiz = 1'b0;
        endcase
        return b;
    endfunction : action_of

    assign resp       = fs1_r[`RESP_LSB +: 4];
    assign cap        = ctrl_r[`CAP_LSB +: 4];
    assign retry_wait = ctrl_r[`WAIT_LSB +: 16];

    // Threshold and filter lookup
    lock_lookup_rom u_rom (
        .ref_clk    (ref_clk),
        .cmp_code   (fs1_r[`CMP_THR_LSB +: 4]),
        .adc_code   (fs1_r[`ADC_THR_LSB +: 4]),
        .filt_code  (fs1_r[`FILT_LSB +: 4]),
        .cmp_thr_ma (cmp_threshold_ma),
        .adc_thr_ma (adc_thr_ma),
        .filt_ticks (filt_ticks)
    );

    // Avalon handshake: one wait cycle, then one ready cycle
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wait_r <= 1'b1;
        end else if (!wait_r) begin
            wait_r <= 1'b1;
        end else if (avs_req.read || avs_req.write) begin
            wait_r <= 1'b0;
        end
    end

    assign wr_en = avs_req.write && !wait_r;

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit(avs_req.address, `FS1_INDEX)) begin
            rd_mux = fs1_r;
        end else if (hit(avs_req.address, `CTRL_INDEX)) begin
            rd_mux = {ctrl_r[31:1], 1'b0};
        end else if (hit(avs_req.address, `STAT_INDEX)) begin
            rd_mux = {28'h0000000, status_r};
        end else if (hit(avs_req.address, `MASK_INDEX)) begin
            rd_mux = {28'h0000000, mask_r};
        end else if (hit(avs_req.address, `INFO_INDEX)) begin
            rd_mux = {24'h000000, retry_cnt_r, state_r};
        end
    end

    // Read data captured in the wait cycle
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_req.read && wait_r) begin
            rdata_r <= rd_mux;
        end
    end

    // Configuration registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            fs1_r  <= `FS1_RESET;
            ctrl_r <= `CTRL_RESET;
            mask_r <= `MASK_RESET;
        end else if (wr_en) begin
            if (hit(avs_req.address, `FS1_INDEX)) begin
                fs1_r <= avs_req.writedata;
            end
            if (hit(avs_req.address, `CTRL_INDEX)) begin
                ctrl_r <= avs_req.writedata;
            end
            if (hit(avs_req.address, `MASK_INDEX)) begin
                mask_r <= avs_req.writedata[3:0];
            end
        end
    end

    // Fault clear pulse from control write
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            clear_r <= 1'b0;
        end else begin
            clear_r <= wr_en && hit(avs_req.address, `CTRL_INDEX)
                       && avs_req.writedata[`CTRL_CLEAR_BIT];
        end
    end

    // Comparator pin synchroniser
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cmp_meta_r <= 1'b0;
            cmp_sync_r <= 1'b0;
        end else begin
            cmp_meta_r <= cmp_trip;
            cmp_sync_r <= cmp_meta_r;
        end
    end

    // ADC over-threshold flag, updated per sample
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            adc_over_r <= 1'b0;
        end else if (adc_valid) begin
            adc_over_r <= adc_current_ma > adc_thr_ma;
        end
    end

    assign over      = cmp_sync_r || adc_over_r;
    assign detect_en = (state_r == ST_IDLE) && (resp <= 4'h8);

    // Filter timer, restarts whenever current drops
    always_ff @(posedge ref_clk) begin
        if (!reset_n || !over || !detect_en) begin
            pre_r <= 16'h0000;
            deg_r <= 14'h0000;
        end else if (pre_r == 16'(TICK_CYCLES - 1)) begin
            pre_r <= 16'h0000;
            deg_r <= deg_r + 14'h0001;
        end else begin
            pre_r <= pre_r + 16'h0001;
        end
    end

    assign lock_event = detect_en && over && (deg_r == filt_ticks);

    // Retry wait timer
    always_ff @(posedge ref_clk) begin
        if (!reset_n || state_r != ST_RETRY) begin
            rpre_r   <= 16'h0000;
            rticks_r <= 16'h0000;
        end else if (rpre_r == 16'(TICK_CYCLES - 1)) begin
            rpre_r   <= 16'h0000;
            rticks_r <= rticks_r + 16'h0001;
        end else begin
            rpre_r <= rpre_r + 16'h0001;
        end
    end

    assign retry_done = (state_r == ST_RETRY) && (rticks_r >= retry_wait);
    assign exhaust    = retry_cnt_r >= cap;

    // Next state and held action
    always_comb begin
        state_nxt  = state_r;
        action_nxt = action_r;
        case (state_r)
            ST_IDLE: begin
                if (lock_event) begin
                    action_nxt = action_of(resp);
                    if (resp <= 4'h3) begin
                        state_nxt = ST_LATCHED;
                    end else if (resp <= 4'h7) begin
                        state_nxt = exhaust ? ST_LATCHED : ST_RETRY;
                    end else begin
                        state_nxt = ST_REPORT;
                    end
                end
            end
            ST_RETRY: begin
                if (clear_r || retry_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_LATCHED, ST_REPORT: begin
                if (clear_r) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_r  <= ST_IDLE;
            action_r <= '{hiz: 1'b0, hs_on: 1'b0, ls_on: 1'b0};
        end else begin
            state_r  <= state_nxt;
            action_r <= action_nxt;
        end
    end

    // Retry counter, cleared by fault clear
    always_ff @(posedge ref_clk) begin
        if (!reset_n || clear_r) begin
            retry_cnt_r <= 4'h0;
        end else if (retry_done && retry_cnt_r != 4'hf) begin
            retry_cnt_r <= retry_cnt_r + 4'h1;
        end
    end

    // Gate and fault pin outputs
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            bridge_r  <= '{hiz: 1'b0, hs_on: 1'b0, ls_on: 1'b0};
            fault_n_r <= 1'b1;
        end else begin
            bridge_r  <= (state_nxt == ST_LATCHED || state_nxt == ST_RETRY)
                         ? action_nxt : bridge_cmd_t'(3'h0);
            fault_n_r <= (state_nxt == ST_IDLE);
        end
    end

    // Sticky status; a new event wins over a clear
    always_comb begin
        status_nxt = status_r;
        if (wr_en && hit(avs_req.address, `STAT_INDEX)) begin
            status_nxt = status_r & ~avs_req.writedata[3:0];
        end
        if (lock_event) begin
            status_nxt[`ST_DETECT] = 1'b1;
        end
        if (state_r == ST_IDLE && state_nxt == ST_LATCHED) begin
            status_nxt[`ST_LATCH] = 1'b1;
        end
        if (state_r == ST_IDLE && state_nxt == ST_RETRY) begin
            status_nxt[`ST_RETRY] = 1'b1;
        end
        if (lock_event && resp >= 4'h4 && resp <= 4'h7 && exhaust) begin
            status_nxt[`ST_EXHAUST] = 1'b1;
        end
    end

    // Status and interrupt registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            status_r <= 4'h0;
            irq_r    <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq_r    <= |(status_nxt & mask_r);
        end
    end

    assign avs_readdata          = rdata_r;
    assign avs_waitrequest       = wait_r;
    assign fault_indicator_pin_n = fault_n_r;
    assign bridge                = bridge_r;
    assign irq                   = irq_r;

    // Helper: cycles of unbroken over-threshold while detection is on
    logic [31:0] run_r;
    always_ff @(posedge ref_clk) begin
        if (!reset_n || !over || !detect_en) begin
            run_r <= 32'h0000_0000;
        end else begin
            run_r <= run_r + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_idle_event;
        state_r == ST_IDLE && lock_event;
    endsequence
    sequence s_retry_start;
        s_idle_event ##0 (resp >= 4'h4 && resp <= 4'h7 && !exhaust);
    endsequence

    a_latch_tristate: assert property (s_idle_event ##0 resp <= 4'h1
        |=> state_r == ST_LATCHED && bridge.hiz && !fault_indicator_pin_n)
        else $error("tristate latch not taken");
    a_latch_high_brake: assert property (s_idle_event ##0 resp == 4'h2
        |=> bridge.hs_on && !bridge.ls_on && !fault_indicator_pin_n)
        else $error("high side brake not taken");
    a_latch_low_brake: assert property (s_idle_event ##0 resp == 4'h3
        |=> bridge.ls_on && !bridge.hs_on && !fault_indicator_pin_n)
        else $error("low side brake not taken");
    a_retry_wait_start: assert property (s_retry_start
        |=> state_r == ST_RETRY && !fault_indicator_pin_n)
        else $error("retry wait not entered");
    a_retry_count_step: assert property (retry_done && !clear_r
        && retry_cnt_r != 4'hf |=> retry_cnt_r == $past(retry_cnt_r) + 4'h1)
        else $error("retry not counted");
    a_retry_cap_latch: assert property (s_idle_event ##0 resp == 4'h6 && exhaust
        |=> state_r == ST_LATCHED && bridge.hs_on && status_r[`ST_EXHAUST])
        else $error("cap overrun did not latch");
    a_report_only: assert property (state_r == ST_REPORT
        |-> !bridge.hiz && !bridge.hs_on && !bridge.ls_on && !fault_indicator_pin_n)
        else $error("report mode acted on bridge");
    a_lock_disabled: assert property (resp >= 4'h9 |-> !lock_event)
        else $error("event while disabled");
    a_filter_time: assert property (lock_event
        |-> run_r == 32'(filt_ticks) * 32'(TICK_CYCLES))
        else $error("event before full filter time");
    a_fault_hold: assert property (state_r == ST_LATCHED && !clear_r
        |=> state_r == ST_LATCHED && !fault_indicator_pin_n)
        else $error("latched fault dropped");
    a_cmp_threshold: assert property (fs1_r[`CMP_THR_LSB +: 4] == 4'hf
        ##1 $stable(fs1_r) |-> cmp_threshold_ma == `THR_F)
        else $error("comparator threshold wrong");
endmodule : lock_current_fault_handler

// File: test/tb.sv
// Self-checking bench for the lock-current fault handler
`timescale 1ns/1ps
`include "lock_current_consts.svh"
module tb;
    import lock_pkg::*;
    localparam int TC = 4;                     // Cycles per tick, shortened
    localparam logic [11:0] fs1_addr  = {`FS1_INDEX, 2'b00};
    localparam logic [11:0] ctrl_addr = {`CTRL_INDEX, 2'b00};
    localparam logic [11:0] stat_addr = {`STAT_INDEX, 2'b00};
    localparam logic [11:0] mask_addr = {`MASK_INDEX, 2'b00};
    localparam logic [11:0] info_addr = {`INFO_INDEX, 2'b00};
    logic              ref_clk;
    logic              reset_n;
    avs_req_t          avs_req;
    logic       [31:0] avs_readdata;
    logic              avs_waitrequest;
    logic              cmp_trip;
    logic       [15:0] adc_current_ma;
    logic              adc_valid;
    logic       [15:0] cmp_threshold_ma;
    logic              fault_indicator_pin_n;
    bridge_cmd_t       bridge;
    logic              irq;
    int                error_cnt;
    int                samples_checked;
    int                n;
    logic       [31:0] rd;
    logic       [31:0] ctrl_v;
    // Threshold currents in mA, 0.125 A to 8.0 A
    logic [15:0] thr_ma [16] = '{16'h007d, 16'h00fa, 16'h01f4, 16'h03e8, 16'h05dc, 16'h07d0,
        16'h09c4, 16'h0bb8, 16'h0dac, 16'h0fa0, 16'h1194, 16'h1388, 16'h157c, 16'h1770,
        16'h1b58, 16'h1f40};

    lock_current_fault_handler #(.TICK_CYCLES(TC)) dut_u (
        .ref_clk              (ref_clk),
        .reset_n              (reset_n),
        .avs_req              (avs_req),
        .avs_readdata         (avs_readdata),
        .avs_waitrequest      (avs_waitrequest),
        .cmp_trip             (cmp_trip),
        .adc_current_ma       (adc_current_ma),
        .adc_valid            (adc_valid),
        .cmp_threshold_ma     (cmp_threshold_ma),
        .fault_indicator_pin_n(fault_indicator_pin_n),
        .bridge               (bridge),
        .irq                  (irq)
    );

    // Clock, 20 ns period
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One Avalon transfer, held until waitrequest is sampled low
    task bus(input logic wr, input logic [11:0] adr, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge ref_clk);
        avs_req <= '{read: !wr, write: wr, address: adr, writedata: wd};
        do begin
            @(posedge ref_clk);
            k++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        chk("wait cycles", k, 32'h2);
        avs_req <= '0;
    endtask : bus

    task wreg(input logic [11:0] adr, input logic [31:0] wd);
        bus(1'b1, adr, wd);
    endtask : wreg

    task rreg(input logic [11:0] adr, input logic [31:0] exp, input string nm);
        bus(1'b0, adr, 32'h0);
        chk(nm, rd, exp);
    endtask : rreg

    // One current sample strobe
    task sample(input logic [15:0] ma);
        @(posedge ref_clk);
        adc_current_ma <= ma;
        adc_valid      <= 1'b1;
        @(posedge ref_clk);
        adc_valid      <= 1'b0;
    endtask : sample

    task cyc(input int c);
        repeat (c) @(posedge ref_clk);
    endtask : cyc

    // Bounded wait for a fault pin level
    task wpin(input logic lvl, input int lim);
        n = 0;
        while (fault_indicator_pin_n !== lvl && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
        chk("fault pin", fault_indicator_pin_n, lvl);
    endtask : wpin

    // Fault clear, then status cleared
    task clr;
        wreg(ctrl_addr, ctrl_v | 32'h1);
        wreg(stat_addr, 32'hf);
    endtask : clr

    function logic [31:0] fs1(input logic [3:0] c, a, r, f);
        return {5'h00, c, a, r, f, 11'h000};
    endfunction : fs1

    task t_reset;
        rreg(fs1_addr, `FS1_RESET, "fs1 reset");
        rreg(ctrl_addr, `CTRL_RESET, "ctrl reset");
        rreg(stat_addr, 32'h0, "status reset");
        rreg(mask_addr, 32'h0, "mask reset");
        rreg(info_addr, 32'h1, "info reset");
        wreg(12'h100, 32'hffff_ffff);
        rreg(12'h100, 32'h0, "unmapped");
        chk("threshold reset", cmp_threshold_ma, thr_ma[0]);
        chk("outputs reset", {fault_indicator_pin_n, bridge, irq}, 5'b10000);
    endtask : t_reset

    task t_thr;
        for (int i = 0; i < 16; i++) begin
            wreg(fs1_addr, fs1(i[3:0], 4'hf - i[3:0], 4'h9, 4'h2));
            cyc(3);
            chk("comparator threshold", cmp_threshold_ma, thr_ma[i]);
            rreg(fs1_addr, fs1(i[3:0], 4'hf - i[3:0], 4'h9, 4'h2), "fs1 readback");
        end
    endtask : t_thr

    // Latched and report modes, ADC threshold edge
    task t_mode(input logic [3:0] r, input logic [2:0] br);
        wreg(fs1_addr, fs1(4'h0, r, r, 4'h2));
        sample(thr_ma[r]);
        cyc(20);
        chk("at threshold", fault_indicator_pin_n, 1'b1);
        sample(thr_ma[r] + 16'h1);
        wpin(1'b0, 30);
        cyc(2);
        chk("bridge action", bridge, br);
        sample(16'h0);
        cyc(20);
        chk("fault held", {fault_indicator_pin_n, bridge}, {1'b0, br});
        rreg(info_addr, (r == 4'h8) ? 32'h8 : 32'h4, "state");
        clr;
        cyc(2);
        chk("fault cleared", {fault_indicator_pin_n, bridge}, 4'b1000);
    endtask : t_mode

    task t_off(input logic [3:0] r);
        wreg(fs1_addr, fs1(4'h0, 4'h0, r, 4'h2));
        sample(16'h1000);
        cyc(30);
        chk("disabled", fault_indicator_pin_n, 1'b1);
        sample(16'h0);
    endtask : t_off

    task t_filt(input logic [3:0] f, input int tk);
        wreg(fs1_addr, fs1(4'h0, 4'h0, 4'h0, f));
        sample(16'h0100);
        wpin(1'b0, 20 * tk * TC);
        chk("filter time", n >= tk * TC && n <= tk * TC + 3, 1'b1);
        sample(16'h0);
        clr;
        sample(16'h0100);
        cyc(tk * TC - 3);
        sample(16'h0);
        cyc(3 * tk * TC);
        chk("dip restarts", fault_indicator_pin_n, 1'b1);
    endtask : t_filt

    task t_cmp;
        wreg(fs1_addr, fs1(4'h5, 4'h0, 4'h2, 4'h2));
        cmp_trip <= 1'b1;
        wpin(1'b0, 40);
        cmp_trip <= 1'b0;
        cyc(2);
        chk("comparator brake", bridge, 3'b010);
        clr;
    endtask : t_cmp

    // Auto retry with a cap of one, wait of three ticks
    task t_retry(input logic [3:0] r, input logic [2:0] br);
        ctrl_v = 32'h0003_0010;
        wreg(ctrl_addr, ctrl_v);
        wreg(fs1_addr, fs1(4'h0, 4'h0, r, 4'h2));
        sample(16'h0100);
        wpin(1'b0, 40);
        rreg(info_addr, 32'h2, "retry wait");
        wpin(1'b1, 40);
        wpin(1'b0, 40);
        cyc(2);
        chk("cap action", {fault_indicator_pin_n, bridge}, {1'b0, br});
        rreg(info_addr, 32'h14, "latched after cap");
        rreg(stat_addr, 32'hf, "retry status");
        sample(16'h0);
        clr;
        rreg(info_addr, 32'h1, "count cleared");
    endtask : t_retry

    task t_irq;
        wreg(mask_addr, 32'h2);
        wreg(fs1_addr, fs1(4'h0, 4'h0, 4'h0, 4'h2));
        sample(16'h0100);
        wpin(1'b0, 40);
        cyc(3);
        chk("irq raised", irq, 1'b1);
        rreg(stat_addr, 32'h3, "status");
        wreg(mask_addr, 32'h0);
        cyc(2);
        chk("irq masked", irq, 1'b0);
        wreg(mask_addr, 32'h2);
        cyc(2);
        chk("irq unmasked", irq, 1'b1);
        sample(16'h0);
        wreg(ctrl_addr, ctrl_v | 32'h1);
        wreg(stat_addr, 32'h2);
        cyc(2);
        chk("irq cleared", irq, 1'b0);
        rreg(stat_addr, 32'h1, "status w1c");
    endtask : t_irq

    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // Main sequence
    initial begin
        reset_n = 1'b0;
        avs_req = '0;
        cmp_trip = 1'b0;
        adc_current_ma = 16'h0;
        adc_valid = 1'b0;
        error_cnt = 0;
        samples_checked = 0;
        ctrl_v = `CTRL_RESET;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset;
        t_thr;
        t_mode(4'h0, 3'b100);
        t_mode(4'h1, 3'b100);
        t_mode(4'h2, 3'b010);
        t_mode(4'h3, 3'b001);
        t_mode(4'h8, 3'b000);
        for (int i = 9; i < 16; i++) t_off(i[3:0]);
        t_filt(4'h0, 2);
        t_filt(4'h3, 5);
        t_filt(4'h4, 10);
        t_cmp;
        t_retry(4'h4, 3'b100);
        t_retry(4'h5, 3'b100);
        t_retry(4'h6, 3'b010);
        t_retry(4'h7, 3'b001);
        t_irq;
        finish_test;
    end

    // Watchdog against a hang
    initial begin
        repeat (40000) @(posedge ref_clk);
        error_cnt++;
        finish_test;
    end
endmodule : tb
